// [inc/hbt_pkg.sv]
// Constants, field layout and state types of the hub bus-timing, port and I/O register bank
//
// Notes on behaviour
// - As controller, SCL stays high for the high count plus 5 oscillator periods.
// - As controller, SCL stays low for the low count plus 5 oscillator periods.
// - Target reuses the low count as SDA setup time before releasing SCL.
// - High and low counts reset to 0x7A, about 5 us per SCL phase.
// - Bits 7:4 route control channels to target port 0 (clear) or 1 (set).
// - Bits 3:0 enable each receiver; all four enabled after reset.
// - Voltage-select bit 7 picks 3.3 V when set, 1.8 V when clear.
// - Override bit 6 clear uses detected level; set uses written fields.
`default_nettype none
package hbt_pkg;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [7:0] IDX_SCL_HIGH = 8'h0a;
  localparam logic [7:0] IDX_SCL_LOW = 8'h0b;
  localparam logic [7:0] IDX_RX_PORT = 8'h0c;
  localparam logic [7:0] IDX_IO_LEVEL = 8'h0d;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SCL_HIGH = 8'h7a;
  localparam logic [7:0] RST_SCL_LOW = 8'h7a;
  localparam logic [7:0] RST_RX_PORT = 8'h0f;
  localparam logic [7:0] RST_IO_LEVEL = 8'h09;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int RX_EN_LSB = 0;
  localparam int MAP_LSB = 4;
  localparam int IO_SEL_BIT = 7;
  localparam int IO_OV_BIT = 6;
  localparam int IO_MODE_LSB = 4;
  localparam logic [1:0] MODE_1V8 = 2'h0;
  localparam logic [1:0] MODE_3V3 = 2'h3;
  localparam logic [3:0] IO_RSVD_VAL = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_PS = 25_000;
  localparam int OSC_PERIOD_PS = 39_996;
  localparam int PHASE_ACC_W = 17;
  localparam logic [CNT_W:0] SCL_EXTRA_TICKS = 9'h005;

  // ----------------------------------------
  // SCL controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCL_IDLE = 3'b001,
    SCL_LOW = 3'b010,
    SCL_HIGH = 3'b100
  } hbt_scl_state_t;

endpackage : hbt_pkg
`default_nettype wire

// [inc/hbt_tmr_if.sv]
// Interface between a phase user and the oscillator-tick phase timer
`default_nettype none
interface hbt_tmr_if;
  import hbt_pkg::*;
  logic start;
  logic [CNT_W-1:0] count;
  logic done;
  logic busy;
  modport ctrl (output start, output count, input done, input busy);
  modport timer (input start, input count, output done, output busy);
endinterface : hbt_tmr_if
`default_nettype wire

// [logic/hbt_phase_timer.sv]
// Phase timer counting a programmed value plus fixed extra oscillator ticks
`default_nettype none
module hbt_phase_timer
  import hbt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Oscillator tick enable
  input wire logic osc_tick_i,
  // Timer request
  hbt_tmr_if.timer tmr
);

  logic [CNT_W:0] rem_r;
  logic [CNT_W:0] rem_nxt;
  logic done;

  // ----------------------------------------
  // Remaining ticks
  // ----------------------------------------
  always_comb begin
    rem_nxt = rem_r;
    // Expiry ignores start, so a user may restart on it without a loop
    done = osc_tick_i && (rem_r == {{CNT_W{1'b0}}, 1'b1});
    if (tmr.start) begin
      rem_nxt = {1'b0, tmr.count} + SCL_EXTRA_TICKS;
    end else if (osc_tick_i && (rem_r != '0)) begin
      rem_nxt = rem_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_r <= '0;
    end else begin
      rem_r <= rem_nxt;
    end
  end

  assign tmr.done = done;
  assign tmr.busy = (rem_r != '0);

endmodule : hbt_phase_timer
`default_nettype wire

// [logic/hbt_regs.sv]
// Bus-timing, receive-port and I/O-level register bank with SCL phase generator
//
// Design decision made here: register access over APB.
`default_nettype none
module hbt_regs
  import hbt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Local I2C clock pin, open drain
  input wire logic scl_in_i,
  output logic scl_out_o,
  output logic scl_oe_o,
  // Controller engine handshake
  input wire logic scl_run_i,
  output logic scl_busy_o,
  // Target engine SDA setup
  input wire logic sda_setup_start_i,
  output logic sda_setup_done_o,
  // Receive ports and control channels
  output logic [NUM_PORTS-1:0] rx_receiver_on_o,
  output logic [NUM_PORTS-1:0] ctrl_channel_target_sel_o,
  // I/O supply level
  input wire logic io_supply_det_i,
  output logic high_voltage_io_select_o,
  output logic [1:0] io_supply_mode_o
);

  localparam int IDX_W = ADDR_W - 2;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W too small to reach the register indices");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    addr_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == IDX_W'(idx));
  endfunction : addr_hit

  logic hit_high;
  logic hit_low;
  logic hit_rx;
  logic hit_io;
  logic hit_any;
  logic setup_ph;
  logic access_ph;
  logic wr_en;

  assign hit_high = addr_hit(paddr_i, IDX_SCL_HIGH);
  assign hit_low = addr_hit(paddr_i, IDX_SCL_LOW);
  assign hit_rx = addr_hit(paddr_i, IDX_RX_PORT);
  assign hit_io = addr_hit(paddr_i, IDX_IO_LEVEL);
  assign hit_any = hit_high | hit_low | hit_rx | hit_io;
  assign setup_ph = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wr_en = access_ph & pwrite_i & hit_any;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_flt_r;
  logic [1:0] pin_flt_nxt;
  logic scl_flt;
  logic det_flt;

  assign pin_raw = {io_supply_det_i, scl_in_i};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_comb begin
      pin_flt_nxt[i] = pin_flt_r[i];
      if (pin_s2_r[i] == pin_s3_r[i]) begin
        pin_flt_nxt[i] = pin_s3_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= 2'b01;
      pin_s2_r <= 2'b01;
      pin_s3_r <= 2'b01;
      pin_flt_r <= 2'b01;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_flt_r <= pin_flt_nxt;
    end
  end

  assign scl_flt = pin_flt_r[0];
  assign det_flt = pin_flt_r[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] high_cnt_r;
  logic [7:0] high_cnt_nxt;
  logic [7:0] low_cnt_r;
  logic [7:0] low_cnt_nxt;
  logic [7:0] rx_ctl_r;
  logic [7:0] rx_ctl_nxt;
  logic io_sel_r;
  logic io_sel_nxt;
  logic io_ov_r;
  logic io_ov_nxt;
  logic [1:0] io_mode_r;
  logic [1:0] io_mode_nxt;

  always_comb begin
    high_cnt_nxt = high_cnt_r;
    low_cnt_nxt = low_cnt_r;
    rx_ctl_nxt = rx_ctl_r;
    io_sel_nxt = io_sel_r;
    io_ov_nxt = io_ov_r;
    io_mode_nxt = io_mode_r;
    if (wr_en && hit_high) begin
      high_cnt_nxt = pwdata_i[7:0];
    end
    if (wr_en && hit_low) begin
      low_cnt_nxt = pwdata_i[7:0];
    end
    if (wr_en && hit_rx) begin
      rx_ctl_nxt = pwdata_i[7:0];
    end
    if (wr_en && hit_io) begin
      io_sel_nxt = pwdata_i[IO_SEL_BIT];
      io_ov_nxt = pwdata_i[IO_OV_BIT];
      io_mode_nxt = pwdata_i[IO_MODE_LSB+:2];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_cnt_r <= RST_SCL_HIGH;
      low_cnt_r <= RST_SCL_LOW;
      rx_ctl_r <= RST_RX_PORT;
      io_sel_r <= RST_IO_LEVEL[IO_SEL_BIT];
      io_ov_r <= RST_IO_LEVEL[IO_OV_BIT];
      io_mode_r <= RST_IO_LEVEL[IO_MODE_LSB+:2];
    end else begin
      high_cnt_r <= high_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      io_sel_r <= io_sel_nxt;
      io_ov_r <= io_ov_nxt;
      io_mode_r <= io_mode_nxt;
    end
  end

  // ----------------------------------------
  // I/O level selection
  // ----------------------------------------
  logic eff_sel;
  logic [1:0] eff_mode;

  always_comb begin
    if (io_ov_r) begin
      eff_sel = io_sel_r;
      eff_mode = io_mode_r;
    end else begin
      eff_sel = det_flt;
      eff_mode = det_flt ? MODE_3V3 : MODE_1V8;
    end
  end

  assign high_voltage_io_select_o = eff_sel;
  assign io_supply_mode_o = eff_mode;
  assign rx_receiver_on_o = rx_ctl_r[RX_EN_LSB+:NUM_PORTS];
  assign ctrl_channel_target_sel_o = rx_ctl_r[MAP_LSB+:NUM_PORTS];

  // ----------------------------------------
  // APB read data and answer
  // ----------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (setup_ph) begin
      rdata_nxt = 32'h0000_0000;
      if (hit_high) begin
        rdata_nxt[7:0] = high_cnt_r;
      end
      if (hit_low) begin
        rdata_nxt[7:0] = low_cnt_r;
      end
      if (hit_rx) begin
        rdata_nxt[7:0] = rx_ctl_r;
      end
      if (hit_io) begin
        rdata_nxt[7:0] = {eff_sel, io_ov_r, eff_mode, IO_RSVD_VAL};
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata_o = rdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~hit_any;

  // ----------------------------------------
  // Oscillator tick from fractional divider
  // ----------------------------------------
  localparam logic [PHASE_ACC_W-1:0] ACC_STEP = PHASE_ACC_W'(CLK_PERIOD_PS);
  localparam logic [PHASE_ACC_W-1:0] ACC_WRAP = PHASE_ACC_W'(OSC_PERIOD_PS);

  logic [PHASE_ACC_W-1:0] acc_r;
  logic [PHASE_ACC_W-1:0] acc_nxt;
  logic osc_tick_r;
  logic osc_tick_nxt;
  logic [PHASE_ACC_W-1:0] acc_sum;

  always_comb begin
    acc_sum = acc_r + ACC_STEP;
    osc_tick_nxt = 1'b0;
    acc_nxt = acc_sum;
    if (acc_sum >= ACC_WRAP) begin
      acc_nxt = acc_sum - ACC_WRAP;
      osc_tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= '0;
      osc_tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      osc_tick_r <= osc_tick_nxt;
    end
  end

  // ----------------------------------------
  // SCL phase generator
  // ----------------------------------------
  hbt_tmr_if scl_tmr ();
  hbt_tmr_if sda_tmr ();

  hbt_phase_timer u_scl_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick_r),
    .tmr(scl_tmr.timer)
  );

  hbt_scl_state_t scl_st_r;
  hbt_scl_state_t scl_st_nxt;
  logic hi_armed_r;
  logic hi_armed_nxt;
  logic scl_start;
  logic [CNT_W-1:0] scl_count;

  always_comb begin
    scl_st_nxt = scl_st_r;
    hi_armed_nxt = hi_armed_r;
    scl_start = 1'b0;
    scl_count = low_cnt_r;
    case (scl_st_r)
      SCL_IDLE: begin
        if (scl_run_i) begin
          scl_st_nxt = SCL_LOW;
          scl_start = 1'b1;
        end
      end
      SCL_LOW: begin
        if (scl_tmr.done) begin
          scl_st_nxt = SCL_HIGH;
          hi_armed_nxt = 1'b0;
        end
      end
      SCL_HIGH: begin
        // high phase once line is high
        if (!hi_armed_r && scl_flt) begin
          scl_start = 1'b1;
          scl_count = high_cnt_r;
          hi_armed_nxt = 1'b1;
        end else if (hi_armed_r && scl_tmr.done) begin
          hi_armed_nxt = 1'b0;
          if (scl_run_i) begin
            scl_st_nxt = SCL_LOW;
            scl_start = 1'b1;
          end else begin
            scl_st_nxt = SCL_IDLE;
          end
        end
      end
      default: begin
        scl_st_nxt = SCL_IDLE;
        hi_armed_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_st_r <= SCL_IDLE;
      hi_armed_r <= 1'b0;
    end else begin
      scl_st_r <= scl_st_nxt;
      hi_armed_r <= hi_armed_nxt;
    end
  end

  // count sampled only at phase start
  assign scl_tmr.start = scl_start;
  assign scl_tmr.count = scl_count;

  assign scl_out_o = 1'b0;
  assign scl_oe_o = (scl_st_r == SCL_LOW);
  assign scl_busy_o = (scl_st_r != SCL_IDLE);

  // ----------------------------------------
  // Target SDA setup interval
  // ----------------------------------------
  hbt_phase_timer u_sda_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick_r),
    .tmr(sda_tmr.timer)
  );

  assign sda_tmr.start = sda_setup_start_i;
  assign sda_tmr.count = low_cnt_r;
  assign sda_setup_done_o = sda_tmr.done;

endmodule : hbt_regs
`default_nettype wire

// [verif/hbt_regs_sva.sv]
// Assertion checker for the hub bus-timing register bank
`default_nettype none
module hbt_regs_sva
  import hbt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // SCL and SDA setup
  input wire logic scl_oe_o,
  input wire logic scl_run_i,
  input wire logic scl_busy_o,
  input wire logic sda_setup_start_i,
  input wire logic sda_setup_done_o,
  // Ports and I/O level
  input wire logic [NUM_PORTS-1:0] rx_receiver_on_o,
  input wire logic [NUM_PORTS-1:0] ctrl_channel_target_sel_o,
  input wire logic high_voltage_io_select_o,
  input wire logic [1:0] io_supply_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic ov_r;
  logic oe_q;
  logic [7:0] lo_r;
  logic [7:0] lo_ph;
  logic [31:0] wd_q;
  int ocnt;
  int scnt;
  function automatic int tk(input logic [7:0] n);
    return (int'(n) + 5) * 39996 / 25000;
  endfunction : tk
  assign wr = psel_i && penable_i && pwrite_i && !pslverr_o;
  // Shadow of low count, override and phase lengths
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_r <= 1'b0;
      oe_q <= 1'b0;
      lo_r <= RST_SCL_LOW;
      lo_ph <= RST_SCL_LOW;
      wd_q <= 32'h0000_0000;
      ocnt <= 0;
      scnt <= 0;
    end else begin
      oe_q <= scl_oe_o;
      wd_q <= pwdata_i;
      ocnt <= scl_oe_o ? ocnt + 1 : 0;
      scnt <= sda_setup_start_i ? 1 : scnt + 1;
      if (wr && paddr_i == 8'h2c) lo_r <= pwdata_i[7:0];
      if (wr && paddr_i == 8'h34) ov_r <= pwdata_i[6];
      if (scl_oe_o && !oe_q) lo_ph <= lo_r;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_run_start;
    scl_run_i && !scl_busy_o;
  endsequence
  sequence s_io_rd;
    psel_i && !penable_i && !pwrite_i && paddr_i == 8'h34;
  endsequence
  property p_run;
    s_run_start |=> scl_oe_o && scl_busy_o;
  endproperty
  a_run: assert property (p_run) else $error("no start");
  property p_low_len;
    $fell(scl_oe_o) |-> ocnt >= tk(lo_ph) - 2 && ocnt <= tk(lo_ph) + 3;
  endproperty
  a_low_len: assert property (p_low_len) else $error("low time");
  property p_setup_len;
    sda_setup_done_o |-> scnt >= tk(lo_r) - 2 && scnt <= tk(lo_r) + 3;
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup time");
  property p_rx_wr;
    wr && paddr_i == 8'h30 |=> rx_receiver_on_o == wd_q[3:0]
      && ctrl_channel_target_sel_o == wd_q[7:4];
  endproperty
  a_rx_wr: assert property (p_rx_wr) else $error("port write");
  property p_rst_vals;
    $fell(rst_i) |-> rx_receiver_on_o == 4'hf && ctrl_channel_target_sel_o == 4'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("port reset");
  property p_ov_wr;
    wr && paddr_i == 8'h34 && pwdata_i[6] |=> high_voltage_io_select_o == wd_q[7]
      && io_supply_mode_o == wd_q[5:4];
  endproperty
  a_ov_wr: assert property (p_ov_wr) else $error("override");
  property p_det;
    !ov_r |-> io_supply_mode_o == {2{high_voltage_io_select_o}};
  endproperty
  a_det: assert property (p_det) else $error("detect mode");
  property p_io_rd;
    s_io_rd |=> prdata_o[3:0] == 4'h0 && prdata_o[31:8] == 24'h00_0000;
  endproperty
  a_io_rd: assert property (p_io_rd) else $error("io read");
endmodule : hbt_regs_sva
bind hbt_regs hbt_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .scl_oe_o,
  .scl_run_i, .scl_busy_o, .sda_setup_start_i, .sda_setup_done_o, .rx_receiver_on_o,
  .ctrl_channel_target_sel_o, .high_voltage_io_select_o, .io_supply_mode_o);
`default_nettype wire

// [verif/hbt_i2c_target.sv]
// Local-bus I2C target model: SCL pull-up with clock stretching
`default_nettype none
module hbt_i2c_target (
  // Clock
  input wire logic clk_i,
  // Bus
  input wire logic ctl_pull_i,
  input wire logic [3:0] stretch_i,
  output logic scl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_r = 4'h0;
  // Holds SCL low a while after the controller lets go
  always_ff @(posedge clk_i) begin
    if (ctl_pull_i) hold_r <= stretch_i;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  assign scl_o = !ctl_pull_i && hold_r == 4'h0;
endmodule : hbt_i2c_target
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the hub bus-timing register bank
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic scl_run_i = 1'b0;
  logic sda_setup_start_i = 1'b0;
  logic io_supply_det_i = 1'b0;
  logic [3:0] stretch = 4'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, scl_in_i, scl_out_o, scl_oe_o, scl_busy_o;
  logic sda_setup_done_o, high_voltage_io_select_o;
  logic [1:0] io_supply_mode_o;
  logic [3:0] rx_receiver_on_o, ctrl_channel_target_sel_o;
  logic [7:0] pv[2] = '{8'ha5, 8'h5a};
  logic [16:0] iot[4] = '{17'h1_00b0, 17'h1_4f40, 17'h0_fff0, 17'h0_8f00};
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int lc;
  int hc;
  always #12.5 ref_clk_i = ~ref_clk_i;
  hbt_regs #(.ADDR_W(8)) DUT (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_in_i, .scl_out_o,
    .scl_oe_o, .scl_run_i, .scl_busy_o, .sda_setup_start_i, .sda_setup_done_o,
    .rx_receiver_on_o, .ctrl_channel_target_sel_o, .io_supply_det_i,
    .high_voltage_io_select_o, .io_supply_mode_o);
  hbt_i2c_target u_tgt (.clk_i(ref_clk_i), .ctl_pull_i(scl_oe_o && !scl_out_o),
    .stretch_i(stretch), .scl_o(scl_in_i));
  function automatic int tk(input int n);
    return (n + 5) * 39996 / 25000;
  endfunction : tk
  function automatic logic near(input int g, input int e);
    return g >= e - 2 && g <= e + 3;
  endfunction : near
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h00_0000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic x);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    `CHK(e, x)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    `CHK(q[7:0], d)
    `CHK(q[31:8], 24'h00_0000)
    `CHK(e, x)
  endtask : rd
  // One SCL low phase then the following high phase, in cycles
  task automatic meas(output int l, output int h);
    l = 0;
    h = 0;
    while (scl_oe_o !== 1'b1) @(negedge ref_clk_i);
    while (scl_oe_o === 1'b1) begin
      l++;
      @(negedge ref_clk_i);
    end
    while (scl_oe_o !== 1'b1) begin
      h++;
      @(negedge ref_clk_i);
    end
  endtask : meas
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h28, 8'h7a, 1'b0);
    rd(8'h2c, 8'h7a, 1'b0);
    rd(8'h30, 8'h0f, 1'b0);
    rd(8'h34, 8'h00, 1'b0);
    $display("test reset done");
    foreach (pv[i]) begin
      wr(8'h30, pv[i], 1'b0);
      rd(8'h30, pv[i], 1'b0);
      `CHK(rx_receiver_on_o, pv[i][3:0])
      `CHK(ctrl_channel_target_sel_o, pv[i][7:4])
    end
    $display("test ports done");
    foreach (iot[i]) begin
      io_supply_det_i <= iot[i][16];
      repeat (8) @(posedge ref_clk_i);
      wr(8'h34, iot[i][15:8], 1'b0);
      rd(8'h34, iot[i][7:0], 1'b0);
      `CHK(high_voltage_io_select_o, iot[i][7])
      `CHK(io_supply_mode_o, iot[i][5:4])
    end
    rd(8'h38, 8'h00, 1'b1);
    wr(8'h29, 8'h00, 1'b1);
    rd(8'h28, 8'h7a, 1'b0);
    $display("test io done");
    wr(8'h28, 8'h0a, 1'b0);
    wr(8'h2c, 8'h08, 1'b0);
    scl_run_i <= 1'b1;
    meas(lc, hc);
    `CHK(near(lc, tk(8)), 1'b1)
    // High side also spans four sync edges and the timer start edge
    `CHK(near(hc, tk(10) + 5), 1'b1)
    `CHK(scl_out_o, 1'b0)
    stretch <= 4'h9;
    fork
      meas(lc, hc);
      wr(8'h2c, 8'h20, 1'b0);
    join
    `CHK(near(lc, tk(8)), 1'b1)
    `CHK(near(hc, tk(10) + 14), 1'b1)
    meas(lc, hc);
    `CHK(near(lc, tk(32)), 1'b1)
    @(posedge ref_clk_i);
    scl_run_i <= 1'b0;
    for (int i = 0; i < 300 && scl_busy_o; i++) @(negedge ref_clk_i);
    `CHK(scl_busy_o, 1'b0)
    $display("test scl done");
    @(posedge ref_clk_i);
    sda_setup_start_i <= 1'b1;
    @(posedge ref_clk_i);
    sda_setup_start_i <= 1'b0;
    lc = 0;
    while (sda_setup_done_o !== 1'b1 && lc < 500) begin
      lc++;
      @(negedge ref_clk_i);
    end
    `CHK(near(lc, tk(32)), 1'b1)
    $display("test setup done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
